// File: shared/ecc_cfg.svh
`ifndef ECC_CFG_SVH
`define ECC_CFG_SVH

// Register indices; byte address is four times the index
`define ECC_IDX_DIR_SEL    8'h80
`define ECC_IDX_FORCE      8'h81
`define ECC_IDX_MASK7      8'h82
`define ECC_IDX_DATA7      8'h83
`define ECC_IDX_TIMER      8'h84
`define ECC_IDX_ACTION     8'h88
`define ECC_IDX_EDGE       8'h8a
`define ECC_IDX_PORT_DATA  8'h8c
`define ECC_IDX_PORT_DIR   8'h8d
`define ECC_IDX_NO_OVW     8'h8e
`define ECC_IDX_SYS_CTL    8'h8f
`define ECC_IDX_CHAN_BASE  8'h90
`define ECC_IDX_HOLD_BASE  8'h98
`define ECC_IDX_PACC_BASE  8'h9c
`define ECC_IDX_PHOLD_BASE 8'ha0
`define ECC_IDX_MOD_CTL    8'ha4
`define ECC_IDX_MOD_COUNT  8'ha5

// Counts of things
`define ECC_NUM_CH   8
`define ECC_NUM_BUF  4
`define ECC_ADDR_W   10

// Capture system control fields
`define ECC_SYS_LATCH     0
`define ECC_SYS_SAT       1
`define ECC_SYS_PAIR_LOW  2
`define ECC_SYS_PAIR_HIGH 3

// Modulus control fields
`define ECC_MOD_EN          0
`define ECC_MOD_SINGLE      1
`define ECC_MOD_ZERO        2
`define ECC_MOD_FORCE_LATCH 3

// Reset and limit values
`define ECC_RST_BYTE 8'h00
`define ECC_RST_WORD 16'h0000
`define ECC_PA_FULL  8'hff

`endif

// File: shared/ecc_pkg.sv
`default_nettype none
package ecc_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbRequest_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wbResponse_type;

  // Output mode/level pair, in its bit encoding order
  typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_LOW, ACT_HIGH} compareAction_type;

  typedef struct packed {
    logic captureEvent;
    logic noOverwrite;
    logic latchMode;
    logic latchEvent;
    logic readCapture;
    logic readHolding;
  } captureControl_type;
endpackage
`default_nettype wire

// File: rtl/capture_slot.sv
`default_nettype none
module capture_slot
  import ecc_pkg::*;
#(
  parameter bit BUFFERED = 1'b0,
  parameter int WIDTH    = 16
) (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire captureControl_type ctl,
  input  wire logic [WIDTH-1:0]   timerValue,
  output logic      [WIDTH-1:0]   captureValue,
  output logic      [WIDTH-1:0]   holdingValue,
  output logic                    captureEmpty,
  output logic                    holdingEmpty
);
  logic capWrite;
  logic shiftToHold;
  logic latchToHold;

  // Write permission per mode; queue mode may push into an empty holding slot
  always_comb begin
    capWrite    = ctl.captureEvent & (!ctl.noOverwrite | captureEmpty |
                  (BUFFERED & !ctl.latchMode & holdingEmpty));
    shiftToHold = BUFFERED & !ctl.latchMode & capWrite &
                  (!ctl.noOverwrite | !captureEmpty);
    latchToHold = BUFFERED & ctl.latchMode & ctl.latchEvent &
                  (!ctl.noOverwrite | holdingEmpty);
  end

  // Data path
  always_ff @(posedge clock) begin
    if (srst) begin
      captureValue <= '0;
      holdingValue <= '0;
    end else begin
      if (capWrite) captureValue <= timerValue;
      if (shiftToHold | latchToHold) holdingValue <= captureValue;
    end
  end

  // Empty status; a new value wins over a read in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      captureEmpty <= 1'b1;
      holdingEmpty <= 1'b1;
    end else begin
      if (capWrite) captureEmpty <= 1'b0;
      else if (latchToHold | ctl.readCapture) captureEmpty <= 1'b1;
      if (shiftToHold | latchToHold) holdingEmpty <= captureEmpty;
      else if (ctl.readHolding) holdingEmpty <= 1'b1;
    end
  end

  sequence guardedCapture;
    ctl.captureEvent & ctl.noOverwrite & !captureEmpty & !BUFFERED & !ctl.readCapture;
  endsequence

  sequence queuePush;
    BUFFERED & !ctl.latchMode & ctl.captureEvent & !ctl.noOverwrite;
  endsequence

  AST_NOVW_HOLD: assert property (@(posedge clock) disable iff (srst)
    guardedCapture |=> (captureValue == $past(captureValue)) && !captureEmpty)
    else $error("Guarded capture register was overwritten");

  AST_QUEUE_SHIFT: assert property (@(posedge clock) disable iff (srst)
    queuePush |=> (holdingValue == $past(captureValue)) &&
                  (captureValue == $past(timerValue)))
    else $error("Queue mode did not shift capture into holding");

  AST_READ_EMPTY: assert property (@(posedge clock) disable iff (srst)
    (ctl.readHolding & !shiftToHold & !latchToHold) |=> holdingEmpty)
    else $error("Holding register not empty after read");
endmodule
`default_nettype wire

// File: rtl/enhanced_capture_compare_channels.sv
// Register access over Wishbone was decided locally.
`include "ecc_cfg.svh"
// Operation
// - Channel select bit 0 makes capture, 1 makes compare.
// - Capture empty after read or latch; holding empty after read.
// - Overwrite clear: every capture replaces the capture register.
// - Non-buffered with overwrite guard: capture only into an empty register.
// - Latch mode copies capture to holding on zero, zero write, force latch.
// - Latch mode without guard: latching overwrites holding even unread.
// - Buffered with guard: holding written only when empty; capture when empty, or in queue mode when holding is empty.
// - Queue mode without guard: old capture moves to holding, new stored.
// - Queue mode holding read moves accumulator to its holding and clears it.
// - Four 8-bit edge accumulators, pairable into 16-bit ones.
// - Saturation bit stops accumulators at all ones.
// - Latch mode accumulators copied and cleared on latch events.
// - Modulus down-counter is time base; latching periodic or single-shot.
// - Enabled compare forces its pin's direction over the port direction bit.
// - Port data writes go to a latch, driven when pin returns to port.
// - Compare force register always reads zero.
// - Force bit performs the compare action now, without any flag.
// - Channel 7 mask on compare channel makes pin output, direction bit kept.
// - Channel 7 compare loads masked port bits from channel 7 data.
// - Channel 7 mask suppresses the pin's own compare action.
// - Simultaneous channel 7 and own match: channel 7 data decides.
// - Main timer is a 16-bit up counter, captured and compared.
// - Action pair: 00 none, 01 toggle, 10 low, 11 high.
`default_nettype none
module enhanced_capture_compare_channels
  import ecc_pkg::*;
#(
  parameter int NUM_CH  = `ECC_NUM_CH,
  parameter int NUM_BUF = `ECC_NUM_BUF
) (
  input  wire logic           clock,
  input  wire logic           srst,
  input  wire wbRequest_type  wbReq,
  output wbResponse_type      wbResp,
  input  wire logic [7:0]     timerPinIn,
  output logic      [7:0]     timerPinOut,
  output logic      [7:0]     timerPinOe
);
  function automatic logic [7:0] lane8(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic inRange(input logic [7:0] i, input logic [7:0] base,
                                   input logic [7:0] n);
    return (i >= base) && (i < 8'(base + n));
  endfunction

  logic [7:0]  dirSel_q, mask7_q, data7_q, portData_q, portDir_q, noOvw_q;
  logic [15:0] action_q, edge_q, timer_q, modLoad_q, modCount_q;
  logic [3:0]  sysCtl_q;
  logic [1:0]  modCtl_q;
  logic        modZero_q;
  logic [15:0] tc_q [NUM_CH];
  logic [7:0]  pa_q [NUM_BUF];
  logic [7:0]  paHold_q [NUM_BUF];
  logic [7:0]  pinSync1_q, pinSync2_q, pinPrev_q, ocLevel_q;
  logic        ack_q;
  logic [31:0] rdData_q, rdNext;

  logic        access, wr, rd;
  logic [7:0]  idx;
  logic [7:0]  edges, capEvent, match, swForce, act, forcedOut, actNz;
  logic [15:0] capVal [NUM_CH];
  logic [15:0] holdVal [NUM_CH];
  logic [7:0]  capEmpty, holdEmpty, readCap, readHold;
  logic        latchMode, zeroEvt, zeroWrite, forceLatch, latchEvent;
  logic [3:0]  paInc, paSatHit, paClear;

  // One access per request; the ack register blocks a second take
  assign access = wbReq.cyc & wbReq.stb & !ack_q;
  assign wr     = access & wbReq.we;
  assign rd     = access & !wbReq.we;
  assign idx    = wbReq.adr[9:2];
  assign wbResp = '{ack: ack_q, dat: rdData_q};
  assign latchMode = sysCtl_q[`ECC_SYS_LATCH];

  // Bus answer one cycle after the request; unmapped reads return zero
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q    <= 1'b0;
      rdData_q <= 32'h0;
    end else begin
      ack_q    <= access;
      rdData_q <= rd ? rdNext : 32'h0;
    end
  end

  // Read data select
  always_comb begin
    rdNext = 32'h0;
    case (idx)
      `ECC_IDX_DIR_SEL:   rdNext = {24'h0, dirSel_q};
      `ECC_IDX_FORCE:     rdNext = 32'h0;
      `ECC_IDX_MASK7:     rdNext = {24'h0, mask7_q};
      `ECC_IDX_DATA7:     rdNext = {24'h0, data7_q};
      `ECC_IDX_TIMER:     rdNext = {16'h0, timer_q};
      `ECC_IDX_ACTION:    rdNext = {16'h0, action_q};
      `ECC_IDX_EDGE:      rdNext = {16'h0, edge_q};
      `ECC_IDX_PORT_DATA: rdNext = {24'h0, (timerPinOe & portData_q) |
                                           (~timerPinOe & pinSync2_q)};
      `ECC_IDX_PORT_DIR:  rdNext = {24'h0, portDir_q};
      `ECC_IDX_NO_OVW:    rdNext = {24'h0, noOvw_q};
      `ECC_IDX_SYS_CTL:   rdNext = {28'h0, sysCtl_q};
      `ECC_IDX_MOD_CTL:   rdNext = {29'h0, modZero_q, modCtl_q};
      `ECC_IDX_MOD_COUNT: rdNext = {16'h0, modCount_q};
      default: begin
        if (inRange(idx, `ECC_IDX_CHAN_BASE, 8'h08))
          rdNext = {16'h0, dirSel_q[idx[2:0]] ? tc_q[idx[2:0]] : capVal[idx[2:0]]};
        else if (inRange(idx, `ECC_IDX_HOLD_BASE, 8'h04))
          rdNext = {16'h0, holdVal[idx[1:0]]};
        else if (inRange(idx, `ECC_IDX_PACC_BASE, 8'h04))
          rdNext = {24'h0, pa_q[idx[1:0]]};
        else if (inRange(idx, `ECC_IDX_PHOLD_BASE, 8'h04))
          rdNext = {24'h0, paHold_q[idx[1:0]]};
      end
    endcase
  end

  // Software control registers
  always_ff @(posedge clock) begin
    if (srst) begin
      dirSel_q   <= `ECC_RST_BYTE;
      mask7_q    <= `ECC_RST_BYTE;
      data7_q    <= `ECC_RST_BYTE;
      action_q   <= `ECC_RST_WORD;
      edge_q     <= `ECC_RST_WORD;
      portData_q <= `ECC_RST_BYTE;
      portDir_q  <= `ECC_RST_BYTE;
      noOvw_q    <= `ECC_RST_BYTE;
      sysCtl_q   <= 4'h0;
      modCtl_q   <= 2'h0;
    end else if (wr) begin
      case (idx)
        `ECC_IDX_DIR_SEL:   dirSel_q   <= lane8(dirSel_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_MASK7:     mask7_q    <= lane8(mask7_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_DATA7:     data7_q    <= lane8(data7_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_ACTION:    action_q   <= lane16(action_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_EDGE:      edge_q     <= lane16(edge_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_PORT_DATA: portData_q <= lane8(portData_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_PORT_DIR:  portDir_q  <= lane8(portDir_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_NO_OVW:    noOvw_q    <= lane8(noOvw_q, wbReq.dat, wbReq.sel);
        `ECC_IDX_SYS_CTL:   if (wbReq.sel[0]) sysCtl_q <= wbReq.dat[3:0];
        `ECC_IDX_MOD_CTL:   if (wbReq.sel[0]) modCtl_q <= wbReq.dat[1:0];
        default: ;
      endcase
    end
  end

  // Compare values; writes to a capture channel are ignored
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int n = 0; n < NUM_CH; n++) tc_q[n] <= `ECC_RST_WORD;
    end else if (wr && inRange(idx, `ECC_IDX_CHAN_BASE, 8'h08) && dirSel_q[idx[2:0]]) begin
      tc_q[idx[2:0]] <= lane16(tc_q[idx[2:0]], wbReq.dat, wbReq.sel);
    end
  end

  // Free running main timer
  always_ff @(posedge clock) begin
    if (srst) timer_q <= `ECC_RST_WORD;
    else timer_q <= 16'(timer_q + 16'h0001);
  end

  // Pin synchroniser; only the second stage feeds edge detection
  always_ff @(posedge clock) begin
    if (srst) begin
      pinSync1_q <= 8'h00;
      pinSync2_q <= 8'h00;
      pinPrev_q  <= 8'h00;
    end else begin
      pinSync1_q <= timerPinIn;
      pinSync2_q <= pinSync1_q;
      pinPrev_q  <= pinSync2_q;
    end
  end

  // Edge select per channel, capture only when in capture mode
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      edges[n]    = (edge_q[2*n]   & pinSync2_q[n] & !pinPrev_q[n]) |
                    (edge_q[2*n+1] & !pinSync2_q[n] & pinPrev_q[n]);
      capEvent[n] = edges[n] & !dirSel_q[n];
      readCap[n]  = rd && (idx == 8'(`ECC_IDX_CHAN_BASE + n)) && !dirSel_q[n];
      readHold[n] = rd && (n < NUM_BUF) && (idx == 8'(`ECC_IDX_HOLD_BASE + n));
    end
  end

  // Latch sources for latch mode
  assign zeroWrite  = wr && (idx == `ECC_IDX_MOD_COUNT) && (lane16(modLoad_q, wbReq.dat,
                      wbReq.sel) == 16'h0000);
  assign forceLatch = wr && (idx == `ECC_IDX_MOD_CTL) && wbReq.sel[0] &&
                      wbReq.dat[`ECC_MOD_FORCE_LATCH];
  assign zeroEvt    = modCtl_q[`ECC_MOD_EN] && (modCount_q == 16'h0001);
  assign latchEvent = latchMode & (zeroEvt | zeroWrite | forceLatch);

  // Capture slots; the low channels carry a holding register
  for (genvar n = 0; n < NUM_CH; n++) begin : gSlot
    captureControl_type ctl;
    assign ctl = '{captureEvent: capEvent[n], noOverwrite: noOvw_q[n],
                   latchMode: latchMode, latchEvent: latchEvent,
                   readCapture: readCap[n], readHolding: readHold[n]};
    capture_slot #(.BUFFERED(n < NUM_BUF), .WIDTH(16)) uSlot (
      .clock        (clock),
      .srst         (srst),
      .ctl          (ctl),
      .timerValue   (timer_q),
      .captureValue (capVal[n]),
      .holdingValue (holdVal[n]),
      .captureEmpty (capEmpty[n]),
      .holdingEmpty (holdEmpty[n])
    );
  end

  // Modulus down-counter; single-shot stops at zero, periodic reloads
  always_ff @(posedge clock) begin
    if (srst) begin
      modLoad_q  <= `ECC_RST_WORD;
      modCount_q <= `ECC_RST_WORD;
    end else if (wr && idx == `ECC_IDX_MOD_COUNT) begin
      modLoad_q  <= lane16(modLoad_q, wbReq.dat, wbReq.sel);
      modCount_q <= lane16(modLoad_q, wbReq.dat, wbReq.sel);
    end else if (zeroEvt) begin
      modCount_q <= modCtl_q[`ECC_MOD_SINGLE] ? 16'h0000 : modLoad_q;
    end else if (modCtl_q[`ECC_MOD_EN] && modCount_q != 16'h0000) begin
      modCount_q <= 16'(modCount_q - 16'h0001);
    end
  end

  // Sticky zero status for software polling; a new zero beats the clear
  always_ff @(posedge clock) begin
    if (srst) modZero_q <= 1'b0;
    else if (zeroEvt) modZero_q <= 1'b1;
    else if (wr && idx == `ECC_IDX_MOD_CTL && wbReq.sel[0] && wbReq.dat[`ECC_MOD_ZERO])
      modZero_q <= 1'b0;
  end

  // Accumulator increments; a pair chains its high half off the low carry
  always_comb begin
    for (int k = 0; k < NUM_BUF; k++) begin
      automatic int lo = k & ~1;
      automatic logic paired = (k >= 2) ? sysCtl_q[`ECC_SYS_PAIR_HIGH]
                                        : sysCtl_q[`ECC_SYS_PAIR_LOW];
      paInc[k]    = paired ? ((k == lo) ? edges[k] : (edges[lo] && pa_q[lo] == `ECC_PA_FULL))
                           : edges[k];
      paSatHit[k] = paired ? (pa_q[lo] == `ECC_PA_FULL && pa_q[lo+1] == `ECC_PA_FULL)
                           : (pa_q[k] == `ECC_PA_FULL);
      paClear[k]  = latchEvent | (!latchMode & readHold[k]);
    end
  end

  // Accumulators and their holding registers; an edge in the clear cycle counts on accumulators 0 and 2 only
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int k = 0; k < NUM_BUF; k++) begin
        pa_q[k]     <= `ECC_RST_BYTE;
        paHold_q[k] <= `ECC_RST_BYTE;
      end
    end else begin
      for (int k = 0; k < NUM_BUF; k++) begin
        if (paClear[k]) begin
          paHold_q[k] <= pa_q[k];
          pa_q[k]     <= {7'h00, paInc[k] & ((k & 1) == 0)};
        end else if (paInc[k] && !(sysCtl_q[`ECC_SYS_SAT] && paSatHit[k])) begin
          pa_q[k] <= 8'(pa_q[k] + 8'h01);
        end
      end
    end
  end

  // Compare match and software force on compare channels
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      match[n]     = dirSel_q[n] && (timer_q == tc_q[n]);
      swForce[n]   = wr && (idx == `ECC_IDX_FORCE) && wbReq.sel[0] && wbReq.dat[n];
      act[n]       = (match[n] | swForce[n]) & dirSel_q[n];
      actNz[n]     = action_q[2*n+1] | action_q[2*n];
      forcedOut[n] = dirSel_q[n] & (mask7_q[n] | actNz[n]);
    end
  end

  // Output levels; channel 7 data wins on masked pins
  always_ff @(posedge clock) begin
    if (srst) begin
      ocLevel_q <= 8'h00;
    end else begin
      for (int n = 0; n < NUM_CH; n++) begin
        if (mask7_q[n]) begin
          if (act[NUM_CH-1]) ocLevel_q[n] <= data7_q[n];
        end else if (act[n]) begin
          case (compareAction_type'(action_q[2*n+:2]))
            ACT_TOGGLE: ocLevel_q[n] <= !ocLevel_q[n];
            ACT_LOW:    ocLevel_q[n] <= 1'b0;
            ACT_HIGH:   ocLevel_q[n] <= 1'b1;
            default:    ocLevel_q[n] <= ocLevel_q[n];
          endcase
        end
      end
    end
  end

  // Pin drive; the port latch drives only when no compare owns the pin
  always_ff @(posedge clock) begin
    if (srst) begin
      timerPinOut <= 8'h00;
      timerPinOe  <= 8'h00;
    end else begin
      timerPinOe  <= forcedOut | portDir_q;
      timerPinOut <= (forcedOut & ocLevel_q) | (~forcedOut & portData_q);
    end
  end

  sequence modHitsOne;
    zeroEvt && !(wr && idx == `ECC_IDX_MOD_COUNT) && !modCtl_q[`ECC_MOD_SINGLE];
  endsequence

  sequence channel7Acts;
    act[NUM_CH-1] && !srst;
  endsequence

  AST_FORCE_READ_ZERO: assert property (@(posedge clock) disable iff (srst)
    (rd && idx == `ECC_IDX_FORCE) |=> wbResp.ack && wbResp.dat == 32'h0)
    else $error("Compare force read returned nonzero");

  AST_FORCED_DIRECTION: assert property (@(posedge clock) disable iff (srst)
    ##1 (($past(forcedOut) & ~timerPinOe) == 8'h00))
    else $error("Compare pin not forced to output");

  AST_OC7_LOAD: assert property (@(posedge clock) disable iff (srst)
    channel7Acts |=> (((ocLevel_q ^ $past(data7_q)) & $past(mask7_q)) == 8'h00))
    else $error("Masked pin not loaded from channel 7 data");

  AST_MASK_SUPPRESS: assert property (@(posedge clock) disable iff (srst)
    !act[NUM_CH-1] |=> (((ocLevel_q ^ $past(ocLevel_q)) & $past(mask7_q)) == 8'h00))
    else $error("Masked pin changed without channel 7 action");

  AST_TOGGLE: assert property (@(posedge clock) disable iff (srst)
    (act[0] && !mask7_q[0] && action_q[1:0] == 2'h1) |=> ocLevel_q[0] != $past(ocLevel_q[0]))
    else $error("Toggle action did not invert output");

  AST_PA_SAT: assert property (@(posedge clock) disable iff (srst)
    (sysCtl_q[`ECC_SYS_SAT] && !sysCtl_q[`ECC_SYS_PAIR_HIGH] &&
     pa_q[NUM_BUF-1] == `ECC_PA_FULL && !paClear[NUM_BUF-1]) |=>
    pa_q[NUM_BUF-1] == `ECC_PA_FULL)
    else $error("Saturated accumulator moved");

  AST_PA_LATCH: assert property (@(posedge clock) disable iff (srst)
    latchEvent |=> (paHold_q[NUM_BUF-1] == $past(pa_q[NUM_BUF-1])) &&
                   (pa_q[NUM_BUF-1] <= 8'h01))
    else $error("Accumulator not latched and cleared");

  AST_MOD_RELOAD: assert property (@(posedge clock) disable iff (srst)
    modHitsOne |=> modCount_q == $past(modLoad_q))
    else $error("Periodic modulus counter did not reload");

  AST_TIMER_UP: assert property (@(posedge clock) disable iff (srst)
    !srst |=> timer_q == 16'($past(timer_q) + 16'h0001))
    else $error("Main timer did not count up");
endmodule
`default_nettype wire

// File: tb/timer_pin_model.sv
`default_nettype none
module timer_pin_model (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] stim,
  output logic      [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // Wire level: device drive where enabled, else the far-side level
  always_comb pinIn = (pinOe & pinOut) | (~pinOe & stim);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`default_nettype none
module tb_top
  import ecc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0]  idx;
    logic [15:0] wr;
    logic [15:0] exp;
  } row_type;
  logic           clock = 1'b0;
  logic           srst = 1'b1;
  wbRequest_type  wbReq = '0;
  wbResponse_type wbResp;
  logic [7:0]     pinIn;
  logic [7:0]     pinOut;
  logic [7:0]     pinOe;
  logic [7:0]     stim = 8'h00;
  int             errors = 0;
  int             comparisons = 0;
  int             cycles = 0;
  logic [31:0]    rd;
  logic [31:0]    tA;
  logic [31:0]    tB;
  logic [31:0]    xA;
  logic [31:0]    xB;
  // Write, then read back; force register always reads zero
  row_type        rows [5] = '{'{8'h80, 16'h00a5, 16'h00a5}, '{8'h81, 16'h00ff, 16'h0000},
                               '{8'h82, 16'h005a, 16'h005a}, '{8'h83, 16'h00c3, 16'h00c3},
                               '{8'h8d, 16'h000f, 16'h000f}};

  enhanced_capture_compare_channels enhanced_capture_compare_channels_i (
    .clock(clock), .srst(srst), .wbReq(wbReq), .wbResp(wbResp),
    .timerPinIn(pinIn), .timerPinOut(pinOut), .timerPinOe(pinOe));
  timer_pin_model timer_pin_model_i (.pinOut(pinOut), .pinOe(pinOe), .stim(stim), .pinIn(pinIn));

  always #2.5 clock = ~clock;

  task automatic give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled, then a cycle idle
  task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d,
                    output logic [31:0] q);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h3, dat: {16'h0000, d}};
    do begin
      @(posedge clock);
    end while (wbResp.ack !== 1'b1);
    q = wbResp.dat;
    wbReq <= '0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d, rd);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 16'h0000, rd);
    chk(rd, exp);
  endtask

  // One rising pulse on a pin, w cycles high then w low
  task automatic pulse(input int ch, input int w);
    stim[ch] <= 1'b1;
    repeat (w) @(posedge clock);
    stim[ch] <= 1'b0;
    repeat (w) @(posedge clock);
  endtask

  // Two rising pulses 40 cycles apart on channel 5, timer read before
  task automatic capRun(input logic [7:0] guard, output logic [31:0] t, output logic [31:0] x);
    wr(8'h8e, {8'h00, guard});
    wb(1'b0, 8'h95, 16'h0000, x);
    wb(1'b0, 8'h84, 16'h0000, t);
    repeat (2) pulse(5, 20);
    wb(1'b0, 8'h95, 16'h0000, x);
  endtask

  // Hang guard; the whole run needs about fifteen hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    foreach (rows[i]) begin
      rdc(rows[i].idx, 32'h0);
      wr(rows[i].idx, rows[i].wr);
      rdc(rows[i].idx, {16'h0000, rows[i].exp});
    end
    rdc(8'h70, 32'h0);
    $display("register table test done");
    // Compare on 0,1,2,4,7; toggle, low, high on pins 0..2
    wr(8'h82, 16'h0000);
    wr(8'h8d, 16'h0000);
    wr(8'h80, 16'h0097);
    wr(8'h88, 16'h0039);
    wr(8'h81, 16'h0007);
    repeat (3) @(posedge clock);
    chk({29'h0, pinOut[2:0]}, 32'h5);
    chk({29'h0, pinOe[2:0]}, 32'h7);
    wr(8'h81, 16'h0007);
    repeat (3) @(posedge clock);
    chk({29'h0, pinOut[2:0]}, 32'h4);
    $display("force test done");
    // Mask pins 2 and 4: channel 7 data wins over pin 2's own set action
    wr(8'h83, 16'h0010);
    wr(8'h82, 16'h0014);
    repeat (3) @(posedge clock);
    chk({31'h0, pinOe[4]}, 32'h1);
    rdc(8'h8d, 32'h0);
    wr(8'h81, 16'h0084);
    repeat (3) @(posedge clock);
    chk({30'h0, pinOut[4], pinOut[2]}, 32'h2);
    wr(8'h83, 16'h0004);
    wr(8'h81, 16'h0004);
    repeat (3) @(posedge clock);
    chk({30'h0, pinOut[4], pinOut[2]}, 32'h2);
    // Port latch on a compare-owned pin shows only once the compare lets go
    wr(8'h8c, 16'h0001);
    wr(8'h8d, 16'h0001);
    repeat (3) @(posedge clock);
    chk({31'h0, pinOut[0]}, 32'h0);
    wr(8'h80, 16'h0096);
    repeat (3) @(posedge clock);
    chk({31'h0, pinOut[0]}, 32'h1);
    $display("channel 7 test done");
    // Guard clear keeps the later capture, guard set the earlier one
    wr(8'h8a, 16'h0400);
    capRun(8'h00, tA, xA);
    capRun(8'h20, tB, xB);
    chk({16'h0, xA[15:0] - tA[15:0]}, {16'h0, xB[15:0] - tB[15:0] + 16'd40});
    $display("capture test done");
    // Buffered channel 3: queue mode, then latch mode, with its accumulator
    wr(8'h8a, 16'h0040);
    wb(1'b0, 8'h84, 16'h0000, tA);
    repeat (2) pulse(3, 20);
    rdc(8'h9b, {16'h0, tA[15:0] + 16'd5});
    rdc(8'ha3, 32'h2);
    rdc(8'h9f, 32'h0);
    rdc(8'h93, {16'h0, tA[15:0] + 16'd45});
    wr(8'h8f, 16'h0001);
    wb(1'b0, 8'h84, 16'h0000, tB);
    pulse(3, 20);
    wr(8'ha5, 16'h0000);
    rdc(8'h9b, {16'h0, tB[15:0] + 16'd5});
    rdc(8'ha3, 32'h1);
    rdc(8'h9f, 32'h0);
    // Modulus counter periodic, then single-shot stopping at zero
    wr(8'ha4, 16'h0001);
    wr(8'ha5, 16'h0005);
    repeat (8) @(posedge clock);
    rdc(8'ha4, 32'h5);
    wr(8'ha4, 16'h0003);
    wr(8'ha5, 16'h0005);
    repeat (8) @(posedge clock);
    rdc(8'ha5, 32'h0);
    // Saturating accumulator: 256 edges would wrap to zero without it
    wr(8'h8f, 16'h0003);
    repeat (256) pulse(3, 2);
    rdc(8'h9f, 32'hff);
    $display("buffered channel test done");
    // Second reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk({24'h0, pinOe}, 32'h0);
    rdc(8'h80, 32'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
